// >>> hdl/rlis_defs_defs.svh
/*
 * Offsets, field positions, reset values and response codes of the receive line input select block.
 * Assumes it is included by bare name from the receive line input select module only.
 */
// Overview of operation
// - While the internal line interface unit is enabled the external receive line clock is used only as a bit of the live register.
// - The analog receive pair, seen through the line interface unit, is the source only while that unit is enabled.
// - In a bipolar code with the unit disabled, a high on the positive pulse input means a positive line pulse.
// - In a bipolar code with the unit disabled, a high on the negative pulse input means a negative line pulse.
// - External data is sampled on the rising edge of the reference clock, or the falling edge when it is inverted.
// - The reference clock is the receive line clock input, or the recovered receive clock output if so selected.
// - In unipolar mode the shared positive input carries already decoded receive data, taken as plain data.
// - In unipolar mode the violation counter advances once per reference cycle with the violation input high.
// - The line clock input and each external data or violation input have their own polarity inversion setting.
// - The receive line clock input can also serve as the reference for receive and transmit serial side outputs.
`ifndef RLIS_DEFS_SVH
`define RLIS_DEFS_SVH

`define RLIS_ADDR_W 5
`define RLIS_OFF_CTRL 5'h00
`define RLIS_OFF_STATUS 5'h04
`define RLIS_OFF_MASK 5'h08
`define RLIS_OFF_BPVCNT 5'h0c
`define RLIS_OFF_LIVE 5'h10

`define RLIS_CTRL_W 6
`define RLIS_CTRL_LIU_EN 0
`define RLIS_CTRL_UNI 1
`define RLIS_CTRL_REF_SEL 2
`define RLIS_CTRL_CLK_INV 3
`define RLIS_CTRL_POS_INV 4
`define RLIS_CTRL_NEG_INV 5
`define RLIS_RST_CTRL 6'h01

`define RLIS_ST_W 3
`define RLIS_ST_BPV 0
`define RLIS_ST_SAT 1
`define RLIS_ST_BOTH 2
`define RLIS_RST_STATUS 3'h0
`define RLIS_RST_MASK 3'h0

`define RLIS_RESP_OKAY 2'h0
`define RLIS_RESP_DECERR 2'h3

`endif

// >>> hdl/rlis_pkg.sv
/*
 * Types shared by the receive line input select design.
 * Assumes the field positions of the defs header match the struct bit order.
 */
package rlis_pkg;
	// control word, liu_en in bit 0
	typedef struct packed {
		logic neg_inv;
		logic pos_inv;
		logic clk_inv;
		logic ref_sel;
		logic unipolar_line_mode;
		logic liu_en;
	} rlis_ctrl_t;

	// one line symbol as seen by the decoder
	typedef struct packed {
		logic pos;
		logic neg;
	} rlis_line_t;

	// which clock paces the sampling
	typedef enum logic [2:0] {
		RLIS_SRC_LIU = 3'b001,
		RLIS_SRC_LINE = 3'b010,
		RLIS_SRC_RECOV = 3'b100
	} rlis_src_t;
endpackage : rlis_pkg

// >>> hdl/rlis_rx_line_input_select.sv
/*
 * Receive line input select for one port: chooses the on-chip line interface unit or the external line pins,
 * samples the external pins on a selectable, invertible reference clock, and hands symbols to the decoder.
 * Registers are reached over AXI4-Lite. Assumes every line-side input, the line interface unit's recovered clock
 * among them, is asynchronous to aclk and runs well below half the aclk rate, so that its edges can be found by
 * oversampling.
 */
`timescale 1ns/1ns
`include "rlis_defs_defs.svh"
module rlis_rx_line_input_select
	import rlis_pkg::*;
#(
	parameter int BPV_W = 16
)
(
	input wire logic aclk, // block clock, 20 MHz
	input wire logic aresetn, // synchronous reset, active low
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic [`RLIS_ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [`RLIS_ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output logic irq, // level interrupt, high while an unmasked status bit is set
	input wire logic rx_line_clk_in, // receive line clock pin
	input wire logic rx_pulse_pos_in, // positive pulse, or unipolar data in unipolar mode
	input wire logic rx_pulse_neg_in, // negative pulse, or code violation in unipolar mode
	input wire logic liu_rec_clk, // recovered clock of the line unit on the analog pair
	input wire logic liu_rec_pos, // positive pulse found on the analog pair
	input wire logic liu_rec_neg, // negative pulse found on the analog pair
	output logic rx_recovered_clk_out, // recovered receive clock, oversampled copy
	output logic dec_valid, // one-cycle pulse, a new symbol for the decoder
	output rlis_line_t dec_line, // symbol for the decoder
	output logic dec_unipolar, // symbol carries plain data in dec_line.pos
	output logic bpv_inc, // one-cycle pulse, advance the violation counter
	output logic line_ref_tick // one-cycle pulse on each active line clock edge while the unit is disabled
);
	// synchronised line-side levels
	logic [5:0] pin_sync;
	logic line_clk_s;
	logic pos_s;
	logic neg_s;
	logic liu_clk_s;
	logic liu_pos_s;
	logic liu_neg_s;

	// registers
	rlis_ctrl_t ctrl_q;
	logic [`RLIS_ST_W-1:0] status_q;
	logic [`RLIS_ST_W-1:0] status_d;
	logic [`RLIS_ST_W-1:0] mask_q;
	logic [BPV_W-1:0] bpv_cnt_q;
	logic [BPV_W-1:0] bpv_cnt_d;

	// edge detection and selection
	logic ref_prev_q;
	logic line_prev_q;
	logic ref_level;
	logic ref_edge;
	logic line_level;
	logic line_edge;
	rlis_src_t src;
	logic ext_pos;
	logic ext_neg;
	logic sel_pos;
	logic sel_neg;
	logic use_uni;
	logic viol_hit;
	logic both_hit;
	logic cnt_full;

	// bus side
	logic aw_have_q;
	logic w_have_q;
	logic [`RLIS_ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic aw_hs;
	logic w_hs;
	logic do_write;
	logic ar_hs;
	logic wr_ctrl;
	logic wr_mask;
	logic wr_hit;
	logic rd_hit;
	logic rd_status;
	logic [31:0] rd_word;

	// every line-side input passes two flip-flops before any logic reads it
	rlis_sync2 #(
		.W(6)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.d({rx_line_clk_in, rx_pulse_pos_in, rx_pulse_neg_in, liu_rec_clk, liu_rec_pos, liu_rec_neg}),
		.q(pin_sync)
	);

	// unpack the synchronised levels
	assign line_clk_s = pin_sync[5];
	assign pos_s = pin_sync[4];
	assign neg_s = pin_sync[3];
	assign liu_clk_s = pin_sync[2];
	assign liu_pos_s = pin_sync[1];
	assign liu_neg_s = pin_sync[0];

	// pacing source: the unit's own clock wins, so the line clock pin is ignored while it is on
	assign src = ctrl_q.liu_en ? RLIS_SRC_LIU :
		(ctrl_q.ref_sel ? RLIS_SRC_RECOV : RLIS_SRC_LINE);

	// inverted reference turns the falling edge into the sampling edge
	always_comb
	begin
		ref_level = 1'b0;
		unique case (src)
			RLIS_SRC_LIU: ref_level = liu_clk_s;
			RLIS_SRC_LINE: ref_level = line_clk_s ^ ctrl_q.clk_inv;
			RLIS_SRC_RECOV: ref_level = rx_recovered_clk_out ^ ctrl_q.clk_inv;
		endcase
	end

	assign ref_edge = ref_level & ~ref_prev_q;

	// the line clock edge is offered on its own for serial side users
	assign line_level = line_clk_s ^ ctrl_q.clk_inv;
	assign line_edge = line_level & ~line_prev_q;

	// per-input polarity on the external pins
	assign ext_pos = pos_s ^ ctrl_q.pos_inv;
	assign ext_neg = neg_s ^ ctrl_q.neg_inv;

	// analog pair only counts while the unit is enabled, pins only while it is off
	assign sel_pos = ctrl_q.liu_en ? liu_pos_s : ext_pos;
	assign sel_neg = ctrl_q.liu_en ? liu_neg_s : ext_neg;

	// unipolar mode applies to the external pins only
	assign use_uni = ctrl_q.unipolar_line_mode & ~ctrl_q.liu_en;
	assign viol_hit = ref_edge & use_uni & sel_neg;
	assign both_hit = ref_edge & ~use_uni & sel_pos & sel_neg;
	assign cnt_full = &bpv_cnt_q;

	// counter saturates rather than wraps so software never misreads a wrap as few errors
	assign bpv_cnt_d = (viol_hit && !cnt_full) ? bpv_cnt_q + BPV_W'(1) : bpv_cnt_q;

	// edge history
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ref_prev_q <= 1'b0;
			line_prev_q <= 1'b0;
		end
		else if (ce)
		begin
			ref_prev_q <= ref_level;
			line_prev_q <= line_level;
		end
	end

	// recovered clock follows the unit when on, otherwise the line clock pin
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rx_recovered_clk_out <= 1'b0;
		else if (ce)
			rx_recovered_clk_out <= ctrl_q.liu_en ? liu_clk_s : line_clk_s;
	end

	// symbol handed to the decoder on each sampling edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dec_valid <= 1'b0;
			dec_line <= '0;
			dec_unipolar <= 1'b0;
			bpv_inc <= 1'b0;
			line_ref_tick <= 1'b0;
		end
		else if (ce)
		begin
			dec_valid <= ref_edge;
			bpv_inc <= viol_hit;
			line_ref_tick <= line_edge & ~ctrl_q.liu_en;
			if (ref_edge)
			begin
				dec_line.pos <= sel_pos;
				dec_line.neg <= use_uni ? 1'b0 : sel_neg;
				dec_unipolar <= use_uni;
			end
		end
	end

	// violation count, cleared by reset only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bpv_cnt_q <= '0;
		else if (ce)
			bpv_cnt_q <= bpv_cnt_d;
	end

	// bus handshakes and decode
	assign aw_hs = s_axi_awvalid & s_axi_awready;
	assign w_hs = s_axi_wvalid & s_axi_wready;
	assign ar_hs = s_axi_arvalid & s_axi_arready;
	assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
	assign wr_ctrl = do_write & (awaddr_q == `RLIS_OFF_CTRL) & wstrb_q[0];
	assign wr_mask = do_write & (awaddr_q == `RLIS_OFF_MASK) & wstrb_q[0];
	assign wr_hit = (awaddr_q == `RLIS_OFF_CTRL) | (awaddr_q == `RLIS_OFF_STATUS) |
		(awaddr_q == `RLIS_OFF_MASK) | (awaddr_q == `RLIS_OFF_BPVCNT) | (awaddr_q == `RLIS_OFF_LIVE);
	assign rd_hit = (s_axi_araddr == `RLIS_OFF_CTRL) | (s_axi_araddr == `RLIS_OFF_STATUS) |
		(s_axi_araddr == `RLIS_OFF_MASK) | (s_axi_araddr == `RLIS_OFF_BPVCNT) |
		(s_axi_araddr == `RLIS_OFF_LIVE);
	assign rd_status = ar_hs & (s_axi_araddr == `RLIS_OFF_STATUS);

	// read word selection, unused upper bits read as zero
	assign rd_word =
		(s_axi_araddr == `RLIS_OFF_CTRL) ? 32'(ctrl_q) :
		(s_axi_araddr == `RLIS_OFF_STATUS) ? 32'(status_q) :
		(s_axi_araddr == `RLIS_OFF_MASK) ? 32'(mask_q) :
		(s_axi_araddr == `RLIS_OFF_BPVCNT) ? 32'(bpv_cnt_q) :
		(s_axi_araddr == `RLIS_OFF_LIVE) ? {28'h0000000, line_clk_s, rx_recovered_clk_out, sel_pos, sel_neg} :
		32'h00000000;

	// sticky events; a new event in the cycle of the clearing read survives it
	always_comb
	begin
		status_d = rd_status ? `RLIS_ST_W'(0) : status_q;
		if (viol_hit)
			status_d[`RLIS_ST_BPV] = 1'b1;
		if (viol_hit && cnt_full)
			status_d[`RLIS_ST_SAT] = 1'b1;
		if (both_hit)
			status_d[`RLIS_ST_BOTH] = 1'b1;
	end

	// control, status and mask registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q <= `RLIS_RST_CTRL;
			status_q <= `RLIS_RST_STATUS;
			mask_q <= `RLIS_RST_MASK;
		end
		else if (ce)
		begin
			status_q <= status_d;
			if (wr_ctrl)
				ctrl_q <= s_axi_wdata_q_ctrl(wdata_q);
			if (wr_mask)
				mask_q <= wdata_q[`RLIS_ST_W-1:0];
		end
	end

	// interrupt is registered from the next status value so it tracks status_q exactly
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq <= 1'b0;
		else if (ce)
			irq <= |(status_d & (wr_mask ? wdata_q[`RLIS_ST_W-1:0] : mask_q));
	end

	// write address and data may arrive in either order; each is held until the response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end
		else if (ce)
		begin
			if (aw_hs)
			begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			else if (do_write)
				aw_have_q <= 1'b0;
			if (w_hs)
			begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			else if (do_write)
				w_have_q <= 1'b0;
		end
	end

	// write channel readies and response; readies return only after the response is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RLIS_RESP_OKAY;
		end
		else if (ce)
		begin
			if (aw_hs)
				s_axi_awready <= 1'b0;
			if (w_hs)
				s_axi_wready <= 1'b0;
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `RLIS_RESP_OKAY : `RLIS_RESP_DECERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// read channel: one read at a time, data registered at the address handshake
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `RLIS_RESP_OKAY;
		end
		else if (ce)
		begin
			if (ar_hs)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? `RLIS_RESP_OKAY : `RLIS_RESP_DECERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// control field extraction from a written word
	function automatic rlis_ctrl_t s_axi_wdata_q_ctrl(input logic [31:0] w);
		rlis_ctrl_t c;
		c = rlis_ctrl_t'(w[`RLIS_CTRL_W-1:0]);
		return c;
	endfunction : s_axi_wdata_q_ctrl
endmodule : rlis_rx_line_input_select

// >>> hdl/rlis_sync2.sv
/*
 * Two flip-flop synchroniser for a group of independent levels.
 * Assumes each bit is a level that may change at any time relative to aclk.
 */
`timescale 1ns/1ns
module rlis_sync2
#(
	parameter int W = 1
)
(
	input wire logic aclk, // block clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic ce, // clock enable
	input wire logic [W-1:0] d, // asynchronous levels
	output logic [W-1:0] q // synchronised levels
);
	logic [W-1:0] meta_q;

	// first stage is read by the second stage only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q <= '0;
			q <= '0;
		end
		else if (ce)
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : rlis_sync2

// >>> testbench/rlis_line_partner.sv
/*
 * Far side model: external line receiver pins and the unit's recovered outputs.
 * Assumes the bench changes inv and sym only while run is low or as run rises.
 */
`timescale 1ns/1ns
module rlis_line_partner
	import rlis_pkg::*;
(
	input wire logic run, // clocks toggle while high
	input wire logic inv, // sample on falling clock edge
	input wire rlis_line_t sym, // base symbol
	output logic line_clk, // line clock pin
	output logic pos, // pulse or data pin
	output logic neg, // pulse or violation pin
	output logic liu_clk, // unit recovered clock
	output rlis_line_t liu_sym, // unit pulses, held
	output rlis_line_t smp // symbol at last sampling edge
);
	logic t = 1'b0;
	rlis_line_t cur = 2'h0;

	initial
	begin
		line_clk = 1'b0;
		liu_clk = 1'b0;
		smp = 2'h0;
	end
	// clocks park with the reference high, so a later polarity change never looks like a sampling edge
	// line rate scaled down so aclk can oversample it; a real far end keeps the standard line rate
	always #200 if (run || !(line_clk ^ inv)) line_clk = ~line_clk;
	always #240 if (run || !liu_clk) liu_clk = ~liu_clk;
	// data move on the edge opposite the sampling edge, half a period of margin each side
	always @(line_clk)
	begin
		if (line_clk ^ inv)
			smp = cur;
		else
		begin
			t = ~t;
			cur = sym ^ {t, t};
		end
	end
	assign pos = cur.pos;
	assign neg = cur.neg;
	assign liu_sym = {sym.neg, sym.pos};
endmodule : rlis_line_partner

// >>> testbench/rlis_rx_line_input_select_properties.sv
/*
 * Port checker of the receive line input select block.
 * Assumes one aclk domain and a bind to the top module.
 */
`timescale 1ns/1ns
module rlis_rx_line_input_select_properties
	import rlis_pkg::*;
#(
	parameter int BPV_W = 16
)
(
	input wire logic aclk, // clock
	input wire logic aresetn, // reset, low
	input wire logic ce, // enable
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic [1:0] s_axi_bresp, // b resp
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_bready, // b ready
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata, // r data
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready, // r ready
	input wire logic rx_line_clk_in, // line clock
	input wire logic liu_rec_clk, // unit clock
	input wire logic dec_valid, // symbol strobe
	input wire rlis_line_t dec_line, // symbol
	input wire logic dec_unipolar, // plain data
	input wire logic bpv_inc, // violation strobe
	input wire logic line_ref_tick // line edge strobe
);
	logic [3:0] lage_q = 4'hf, rage_q = 4'hf, rst_q = 4'h0;
	logic lclk_q = 1'b0, rclk_q = 1'b0;

	// cycles since each clock pin moved; saturating so a stale level never counts as fresh
	always_ff @(posedge aclk)
	begin
		lclk_q <= rx_line_clk_in;
		rclk_q <= liu_rec_clk;
		lage_q <= (lclk_q != rx_line_clk_in) ? 4'h0 : lage_q + {3'h0, lage_q != 4'hf};
		rage_q <= (rclk_q != liu_rec_clk) ? 4'h0 : rage_q + {3'h0, rage_q != 4'hf};
		rst_q <= !aresetn ? 4'h0 : rst_q + {3'h0, rst_q != 4'hf};
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence b_done;
		s_axi_bvalid && s_axi_bready;
	endsequence

	wr_answer_a: assert property (wr_taken |=> !s_axi_awready ##1 s_axi_bvalid)
		else $error("write response not on time");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	b_release_a: assert property (b_done |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write channel not reopened");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data not on time");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	sym_cause_a: assert property (dec_valid |-> !rst_q[3] || lage_q inside {[4'h2:4'ha]} ||
		rage_q inside {[4'h2:4'ha]} ##1 !dec_valid) else $error("symbol without a clock edge");
	tick_cause_a: assert property (line_ref_tick |-> (!rst_q[3] || lage_q inside {[4'h1:4'h5]})
		##1 !line_ref_tick) else $error("line tick without a line clock edge");
	uni_data_a: assert property (dec_valid && dec_unipolar |-> !dec_line.neg)
		else $error("unipolar symbol carries a negative pulse");
	bpv_strobe_a: assert property (bpv_inc |-> dec_valid && dec_unipolar)
		else $error("violation count outside a unipolar symbol");
endmodule : rlis_rx_line_input_select_properties

bind rlis_rx_line_input_select rlis_rx_line_input_select_properties #(.BPV_W(BPV_W))
	rlis_rx_line_input_select_properties_i (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_line_clk_in, .liu_rec_clk,
	.dec_valid, .dec_line, .dec_unipolar, .bpv_inc, .line_ref_tick);

// >>> testbench/rlis_rx_line_input_select_tb_top.sv
/*
 * Self-checking bench of the receive line input select block.
 * Assumes the line partner model and the bound port checker.
 */
`timescale 1ns/1ns
module rlis_rx_line_input_select_tb_top;
	import rlis_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic rx_line_clk_in, rx_pulse_pos_in, rx_pulse_neg_in, liu_rec_clk;
	logic rx_recovered_clk_out, dec_valid, dec_unipolar, bpv_inc, line_ref_tick;
	rlis_line_t dec_line, liu_sym, smp;
	rlis_line_t p_sym = 2'h0;
	logic p_run = 1'b0, p_inv = 1'b0;
	int num_errors = 0, checks_done = 0, bpv_seen = 0;

	rlis_rx_line_input_select #(.BPV_W(16)) rlis_rx_line_input_select_i (.aclk, .aresetn, .ce, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .irq, .rx_line_clk_in, .rx_pulse_pos_in, .rx_pulse_neg_in, .liu_rec_clk,
		.liu_rec_pos(liu_sym.pos), .liu_rec_neg(liu_sym.neg), .rx_recovered_clk_out, .dec_valid, .dec_line,
		.dec_unipolar, .bpv_inc, .line_ref_tick);
	rlis_line_partner rlis_line_partner_i (.run(p_run), .inv(p_inv), .sym(p_sym), .line_clk(rx_line_clk_in),
		.pos(rx_pulse_pos_in), .neg(rx_pulse_neg_in), .liu_clk(liu_rec_clk), .liu_sym, .smp);

	// 50 ns clock
	always #25 aclk = ~aclk;

	task automatic give_verdict;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// a wait that ran out ends the run
	task automatic tmo(input int n);
		if (n >= 50)
		begin
			num_errors++;
			give_verdict();
		end
	endtask : tmo

	// one edge first so that a back-to-back call never re-raises bready in the step that lowered it
	task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		tmo(n);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		tmo(n);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	// one line run: every symbol is judged against what the far side held at its sampling edge, or against s with pos and neg swapped when the unit is enabled
	task automatic run_syms(input logic [5:0] c, input rlis_line_t s, output int nv, output int nt);
		logic [1:0] r;
		rlis_line_t e;
		logic u;
		int i;
		nv = 0;
		nt = 0;
		u = c[1] & ~c[0];
		p_sym <= s;
		wr(5'h00, {26'h0, c}, r);
		repeat (10) @(posedge aclk);
		p_inv <= c[3];
		for (i = 0; i < 220; i++)
		begin
			p_run <= (i < 200);
			@(posedge aclk);
			e = c[0] ? {s.neg, s.pos} : smp ^ {c[4], c[5]};
			if (u) e.neg = 1'b0;
			if (dec_valid)
			begin
				nv++;
				bpv_seen += u & (smp.neg ^ c[5]);
				cmp(dec_line, e);
				cmp(dec_unipolar, u);
				cmp(bpv_inc, u & (smp.neg ^ c[5]));
			end
			nt += line_ref_tick;
		end
	endtask : run_syms

	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		logic [31:0] ex [4] = '{32'h1, 32'h0, 32'h0, 32'h0};
		foreach (ex[k])
		begin
			rd(5'(k * 4), d, r);
			cmp(d, ex[k]);
			cmp(r, 2'h0);
		end
		rd(5'h14, d, r);
		cmp(d, 32'h0);
		cmp(r, 2'h3);
		wr(5'h14, 32'h3f, r);
		cmp(r, 2'h3);
		wr(5'h08, 32'h7, r);
		rd(5'h08, d, r);
		cmp(d, 32'h7);
		wr(5'h08, 32'h0, r);
		$display("t_regs done");
	endtask : t_regs

	task automatic t_liu;
		int nv, nt;
		run_syms(6'h01, 2'b10, nv, nt);
		cmp(nv > 15, 1'b1);
		cmp(nt, 0);
		$display("t_liu done");
	endtask : t_liu

	task automatic t_pins;
		logic [5:0] cl [6] = '{6'h08, 6'h0c, 6'h10, 6'h20, 6'h04, 6'h00};
		logic [31:0] d;
		logic [1:0] r;
		int nv, nt;
		foreach (cl[k])
		begin
			run_syms(cl[k], 2'b10, nv, nt);
			cmp(nv > 15, 1'b1);
			cmp(nt > 0, 1'b1);
		end
		rd(5'h04, d, r);
		cmp(d, 32'h4);
		$display("t_pins done");
	endtask : t_pins

	task automatic t_uni;
		logic [31:0] d;
		logic [1:0] r;
		int nv, nt;
		bpv_seen = 0;
		run_syms(6'h02, 2'b11, nv, nt);
		rd(5'h0c, d, r);
		cmp(d, bpv_seen);
		cmp(bpv_seen > 5, 1'b1);
		cmp(irq, 1'b0);
		wr(5'h08, 32'h1, r);
		repeat (3) @(posedge aclk);
		cmp(irq, 1'b1);
		rd(5'h04, d, r);
		cmp(d, 32'h1);
		repeat (3) @(posedge aclk);
		cmp(irq, 1'b0);
		$display("t_uni done");
	endtask : t_uni

	// clock enable low must freeze the symbol path and the counter while the line keeps running
	task automatic t_freeze;
		logic [31:0] d;
		logic [1:0] r;
		int nv;
		int i;
		nv = 0;
		ce <= 1'b0;
		p_run <= 1'b1;
		for (i = 0; i < 60; i++)
		begin
			@(posedge aclk);
			if (i == 40) p_run <= 1'b0;
			nv += dec_valid;
		end
		ce <= 1'b1;
		cmp(nv, 0);
		rd(5'h0c, d, r);
		cmp(d, bpv_seen);
		$display("t_freeze done");
	endtask : t_freeze

	// reset for 12 cycles, then the scenarios in turn
	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_liu();
		t_pins();
		t_uni();
		t_freeze();
		give_verdict();
	end
endmodule : rlis_rx_line_input_select_tb_top
